// >>> core/sfa_pkg.sv
// Constants, register map and carriers for the sample FIFO alignment control.
// Assumes a byte-wide register map reached over a 24-bit SPI frame.
package sfa_pkg;
  // SPI frame: 1 bit read flag, 15 address bits, 8 data bits
  localparam logic [4:0] SFA_SPI_LAST_BIT = 5'h17;
  localparam logic [4:0] SFA_SPI_ADDR_DONE = 5'h0F;
  localparam logic [4:0] SFA_SPI_DATA_FIRST = 5'h10;
  // Register offsets
  localparam logic [14:0] SFA_ADDR_DLY_R1 = 15'h0211;
  localparam logic [14:0] SFA_ADDR_DLY_R2 = 15'h0212;
  localparam logic [14:0] SFA_ADDR_DLY_R3 = 15'h0213;
  localparam logic [14:0] SFA_ADDR_ALIGN = 15'h0220;
  // Field positions in the alignment control register
  localparam int SFA_BIT_SYSREF_EN = 0;
  localparam int SFA_BIT_STROBE_ALIGN = 1;
  // Reset values
  localparam logic [7:0] SFA_ALIGN_RESET = 8'h00;
  localparam logic [4:0] SFA_READBACK_RESET = 5'h00;
  localparam logic [2:0] SFA_OFFSET_RESET = 3'h0;
  // Readback offsets per FIFO and LVDS mode
  localparam logic [4:0] SFA_R1_SUB = 5'h01;
  localparam logic [4:0] SFA_R2_SUB_MODE0 = 5'h02;
  localparam logic [4:0] SFA_R2_SUB_OTHER = 5'h00;
  localparam logic [4:0] SFA_R3_SUB_MODE0 = 5'h03;
  localparam logic [4:0] SFA_R3_SUB_OTHER = 5'h01;
  // Counts in DAC clocks
  localparam logic [4:0] SFA_ARRIVAL_MAX = 5'h1F;
  localparam logic [4:0] SFA_SYSREF_PERIOD = 5'h10;
  localparam logic [4:0] SFA_SYSREF_PHASE_NEXT = 5'h01;

  typedef struct packed {
    logic bank0_in_use;
    logic [2:0] bank0_phase;
    logic [2:0] bank2_phase;
  } sfa_lvds_state_s;

  typedef struct packed {
    logic realigned;
    logic misalign;
  } sfa_alarm_s;

  typedef enum logic {
    SFA_ST_IDLE,
    SFA_ST_WAIT_ACK
  } sfa_strobe_e;
endpackage : sfa_pkg

// >>> core/sfa_sample_fifo_align.sv
// Sample FIFO alignment control: SPI registers, SYSREF and strobe realignment,
// alarms and per-FIFO arrival delay readbacks.
// Assumes i_lvds_clk runs while alignment is requested; SPI and SYSREF are pins.
// Contract
// RQ1 - FIFO1 readback is DAC clocks from SYSREF to first sample, minus one
// RQ2 - FIFO2 readback is arrival count minus two in mode zero, else unchanged
// RQ3 - FIFO3 readback is arrival count minus three in mode zero, else minus one
// RQ4 - Writing one over a zero strobe-align bit starts one realignment
// RQ5 - Strobe alignment uses bank 0 when in use, otherwise bank 2
// RQ6 - No continuous realignment to the LVDS receiver; only on request
// RQ7 - A strobe alignment that moves the FIFO sets the realigned alarm
// RQ8 - Software requests strobe alignment only with datapath on and transmit zeroed
// RQ9 - Strobe alignment takes the receiver's present state without awaiting a strobe
// RQ10 - The sender provides a strobe before software requests alignment
// RQ11 - After SYSREF sync, strobe requests ignored until reset or datapath off
// RQ12 - With SYSREF realign enabled, every detected SYSREF edge realigns
// RQ13 - Software holds SYSREF realign enable only in the safe datapath state
// RQ14 - Misaligned SYSREF edge with enable realigns and sets realigned alarm
// RQ15 - With enable off, SYSREF leaves alignment; misaligned edges still flagged
// RQ16 - SYSREF edge close to the enabling write may still be used
// RQ17 - Delay setting gives DAC clocks from SYSREF until FIFO read starts
// RQ18 - Strobe-bit rising write becomes one request pulse in the DAC domain
`timescale 1ns/100ps
`default_nettype none
module sfa_sample_fifo_align
  import sfa_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_core_ce,
  input wire logic i_lvds_clk,
  input wire logic i_spi_sclk,
  input wire logic i_spi_csn,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe,
  input wire logic i_sysref,
  input wire logic i_datapath_enable,
  input wire logic [1:0] i_lvds_mode,
  input wire logic [4:0] i_fifo_delay_setting,
  input wire sfa_lvds_state_s i_lvds_rx,
  input wire logic [2:0] i_lvds_first_sample,
  input wire logic i_alarm_clear,
  output sfa_alarm_s o_alarm,
  output logic [2:0] o_fifo_read_offset,
  output logic o_fifo_realign,
  output logic o_fifo_read_start
);

  function automatic logic [4:0] sub_sat(input logic [4:0] val, input logic [4:0] dec);
    sub_sat = (val > dec) ? (val - dec) : 5'h00;
  endfunction : sub_sat

  logic [7:0] align_reg;
  logic [4:0] arrival [3];
  logic [2:0] sclk_sync, csn_sync, sdi_sync;
  logic [2:0] sysref_sync;
  logic [22:0] spi_shift;
  logic [4:0] spi_cnt;
  logic spi_read;
  logic [7:0] spi_rd_sh;
  logic strobe_req;
  logic sysref_edge, sysref_misaligned, sysref_synced;
  logic [4:0] sysref_phase;
  logic [4:0] arrival_cnt;
  logic arrival_run;
  logic [2:0] arrived;
  sfa_strobe_e strobe_state;
  logic req_tgl, ack_tgl_l;
  logic [1:0] req_sync_l;
  logic req_seen_l;
  logic [2:0] lvds_word;
  logic [2:0] ack_sync;
  logic [2:0] first_tgl_l;
  logic [2:0] first_sync0, first_sync1, first_seen;
  logic [2:0] first_evt;
  logic sclk_rise, sclk_fall, spi_active;
  logic [14:0] spi_addr16;
  logic [7:0] read_data;

  assign spi_active = !csn_sync[1];
  assign sclk_rise = sclk_sync[1] & !sclk_sync[2];
  assign sclk_fall = !sclk_sync[1] & sclk_sync[2];
  assign sysref_edge = sysref_sync[1] & !sysref_sync[2];
  assign sysref_misaligned = sysref_edge && (sysref_phase != 5'h00);
  assign first_evt = first_sync1 ^ first_seen;
  assign spi_addr16 = {spi_shift[13:0], sdi_sync[1]};

  // Readback decode
  always_comb begin
    read_data = 8'h00;
    case (spi_addr16)
      SFA_ADDR_DLY_R1: read_data = {3'h0, sub_sat(arrival[0], SFA_R1_SUB)}; // RQ1
      SFA_ADDR_DLY_R2: read_data = {3'h0, sub_sat(arrival[1],
        (i_lvds_mode == 2'h0) ? SFA_R2_SUB_MODE0 : SFA_R2_SUB_OTHER)}; // RQ2
      SFA_ADDR_DLY_R3: read_data = {3'h0, sub_sat(arrival[2],
        (i_lvds_mode == 2'h0) ? SFA_R3_SUB_MODE0 : SFA_R3_SUB_OTHER)}; // RQ3
      SFA_ADDR_ALIGN: read_data = align_reg;
      default: read_data = 8'h00;
    endcase
  end

  // Pin synchronisers; only stage 1 onward is read
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_sync <= 3'h0;
      csn_sync <= 3'h7;
      sdi_sync <= 3'h0;
      sysref_sync <= 3'h0;
    end else if (i_core_ce) begin
      sclk_sync <= {sclk_sync[1:0], i_spi_sclk};
      csn_sync <= {csn_sync[1:0], i_spi_csn};
      sdi_sync <= {sdi_sync[1:0], i_spi_sdi};
      sysref_sync <= {sysref_sync[1:0], i_sysref};
    end
  end

  // SPI slave, oversampled in the DAC clock domain
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      spi_shift <= 23'h0;
      spi_cnt <= 5'h00;
      spi_read <= 1'b0;
      spi_rd_sh <= 8'h00;
      o_spi_sdo <= 1'b0;
    end else if (i_core_ce) begin
      if (!spi_active) begin
        spi_cnt <= 5'h00;
      end else if (sclk_rise) begin
        spi_shift <= {spi_shift[21:0], sdi_sync[1]};
        spi_cnt <= (spi_cnt == SFA_SPI_LAST_BIT) ? 5'h00 : spi_cnt + 5'h01;
        if (spi_cnt == SFA_SPI_ADDR_DONE) begin
          spi_read <= spi_shift[14];
          spi_rd_sh <= read_data;
        end
      end else if (sclk_fall && spi_cnt >= SFA_SPI_DATA_FIRST) begin
        o_spi_sdo <= spi_rd_sh[7];
        spi_rd_sh <= {spi_rd_sh[6:0], 1'b0};
      end
    end
  end

  assign o_spi_sdo_oe = spi_active && spi_read && (spi_cnt >= SFA_SPI_DATA_FIRST);

  // Alignment control register and strobe request pulse
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      align_reg <= SFA_ALIGN_RESET;
      strobe_req <= 1'b0;
    end else if (i_core_ce) begin
      strobe_req <= 1'b0;
      if (spi_active && sclk_rise && spi_cnt == SFA_SPI_LAST_BIT && !spi_shift[22] &&
          spi_shift[21:7] == SFA_ADDR_ALIGN) begin
        align_reg <= {spi_shift[6:0], sdi_sync[1]};
        strobe_req <= spi_shift[SFA_BIT_STROBE_ALIGN - 1] &&
                      !align_reg[SFA_BIT_STROBE_ALIGN]; // RQ4 RQ18
      end
    end
  end

  // SYSREF phase tracking and sync state
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sysref_phase <= 5'h00;
      sysref_synced <= 1'b0;
    end else if (i_core_ce) begin
      if (sysref_edge && align_reg[SFA_BIT_SYSREF_EN]) begin
        sysref_phase <= SFA_SYSREF_PHASE_NEXT; // RQ12 RQ16
      end else if (sysref_phase == SFA_SYSREF_PERIOD - 5'h01) begin
        sysref_phase <= 5'h00;
      end else begin
        sysref_phase <= sysref_phase + 5'h01;
      end
      if (!i_datapath_enable) begin
        sysref_synced <= 1'b0; // RQ11
      end else if (sysref_edge && align_reg[SFA_BIT_SYSREF_EN]) begin
        sysref_synced <= 1'b1;
      end
    end
  end

  // Strobe alignment handshake and FIFO offset
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strobe_state <= SFA_ST_IDLE;
      req_tgl <= 1'b0;
      ack_sync <= 3'h0;
      o_fifo_read_offset <= SFA_OFFSET_RESET;
    end else if (i_core_ce) begin
      ack_sync <= {ack_sync[1:0], ack_tgl_l};
      case (strobe_state)
        SFA_ST_IDLE: begin
          if (strobe_req && !sysref_synced) begin // RQ6 RQ11
            req_tgl <= !req_tgl;
            strobe_state <= SFA_ST_WAIT_ACK;
          end
        end
        SFA_ST_WAIT_ACK: begin
          if (ack_sync[2] != ack_sync[1]) begin
            o_fifo_read_offset <= lvds_word; // RQ9
            strobe_state <= SFA_ST_IDLE;
          end
        end
        default: strobe_state <= SFA_ST_IDLE;
      endcase
    end
  end

  // Realign pulse and sticky alarms; set wins over clear
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fifo_realign <= 1'b0;
      o_alarm <= '0;
    end else if (i_core_ce) begin
      o_fifo_realign <= (strobe_state == SFA_ST_WAIT_ACK && ack_sync[2] != ack_sync[1] &&
                         lvds_word != o_fifo_read_offset) ||
                        (sysref_misaligned && align_reg[SFA_BIT_SYSREF_EN]);
      o_alarm.realigned <= (o_alarm.realigned && !i_alarm_clear) ||
        (strobe_state == SFA_ST_WAIT_ACK && ack_sync[2] != ack_sync[1] &&
         lvds_word != o_fifo_read_offset) || // RQ7
        (sysref_misaligned && align_reg[SFA_BIT_SYSREF_EN]); // RQ14
      o_alarm.misalign <= (o_alarm.misalign && !i_alarm_clear) || sysref_misaligned; // RQ15
    end
  end

  // Arrival measurement after each SYSREF edge
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      arrival_cnt <= 5'h00;
      arrival_run <= 1'b0;
      arrived <= 3'h0;
      first_sync0 <= 3'h0;
      first_sync1 <= 3'h0;
      first_seen <= 3'h0;
      o_fifo_read_start <= 1'b0;
      for (int k = 0; k < 3; k++) begin
        arrival[k] <= SFA_READBACK_RESET;
      end
    end else if (i_core_ce) begin
      first_sync0 <= first_tgl_l;
      first_sync1 <= first_sync0;
      first_seen <= first_sync1;
      o_fifo_read_start <= arrival_run && (arrival_cnt == i_fifo_delay_setting); // RQ17
      if (sysref_edge) begin
        arrival_cnt <= 5'h00;
        arrival_run <= 1'b1;
        arrived <= 3'h0;
      end else if (arrival_run) begin
        if (arrival_cnt != SFA_ARRIVAL_MAX) begin
          arrival_cnt <= arrival_cnt + 5'h01;
        end
        for (int k = 0; k < 3; k++) begin
          if (first_evt[k] && !arrived[k]) begin
            arrived[k] <= 1'b1;
            arrival[k] <= arrival_cnt; // RQ1 RQ2 RQ3
          end
        end
      end
    end
  end

  // LVDS clock domain: capture receiver state on request, toggle first-sample events
  always_ff @(posedge i_lvds_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_sync_l <= 2'h0;
      req_seen_l <= 1'b0;
      ack_tgl_l <= 1'b0;
      lvds_word <= SFA_OFFSET_RESET;
      first_tgl_l <= 3'h0;
    end else begin
      req_sync_l <= {req_sync_l[0], req_tgl};
      req_seen_l <= req_sync_l[1];
      first_tgl_l <= first_tgl_l ^ i_lvds_first_sample;
      if (req_sync_l[1] != req_seen_l) begin
        lvds_word <= i_lvds_rx.bank0_in_use ? i_lvds_rx.bank0_phase
                                            : i_lvds_rx.bank2_phase; // RQ5
        ack_tgl_l <= !ack_tgl_l;
      end
    end
  end

  strobe_once_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RQ6
    (strobe_state == SFA_ST_WAIT_ACK) |=> $stable(req_tgl))
    else $error("second strobe request started while busy");
  strobe_start_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RQ4
    (i_core_ce && strobe_req && !sysref_synced && strobe_state == SFA_ST_IDLE)
      |=> (req_tgl != $past(req_tgl)))
    else $error("strobe request not forwarded");
  strobe_lock_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RQ11
    (sysref_synced && strobe_state == SFA_ST_IDLE) |=> $stable(req_tgl))
    else $error("strobe accepted after SYSREF sync");
  rise_only_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RQ4
    strobe_req |-> $past(!align_reg[SFA_BIT_STROBE_ALIGN]) || $past(!i_core_ce))
    else $error("strobe request without zero-to-one write");
  sysref_realign_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RQ12
    (i_core_ce && sysref_edge && align_reg[SFA_BIT_SYSREF_EN])
      |=> sysref_phase == SFA_SYSREF_PHASE_NEXT)
    else $error("SYSREF edge did not realign");
  misalign_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RQ15
    (i_core_ce && sysref_misaligned) |=> o_alarm.misalign)
    else $error("misaligned SYSREF not flagged");
  realign_alarm_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RQ14
    (i_core_ce && sysref_misaligned && align_reg[SFA_BIT_SYSREF_EN])
      |=> o_alarm.realigned && o_fifo_realign)
    else $error("SYSREF realign not reported");
  no_realign_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RQ15
    (i_core_ce && sysref_edge && !align_reg[SFA_BIT_SYSREF_EN])
      |=> sysref_phase != SFA_SYSREF_PHASE_NEXT || $past(sysref_phase) == 5'h00)
    else $error("SYSREF moved alignment while disabled");
  strobe_alarm_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RQ7
    (i_core_ce && o_fifo_read_offset != $past(o_fifo_read_offset)) |-> o_alarm.realigned)
    else $error("offset moved without realigned alarm");
  read_start_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RQ17
    o_fifo_read_start |-> $past(arrival_cnt) == $past(i_fifo_delay_setting))
    else $error("read start at wrong delay");
  bank_select_a: assert property (@(posedge i_lvds_clk) disable iff (!i_rstn) // RQ5
    (req_sync_l[1] != req_seen_l && !i_lvds_rx.bank0_in_use)
      |=> lvds_word == $past(i_lvds_rx.bank2_phase))
    else $error("wrong LVDS bank used for alignment");

endmodule : sfa_sample_fifo_align
`default_nettype wire

// >>> tb/sfa_lvds_partner.sv
// LVDS far-end model: receiver alignment state and first-sample pulses.
// Assumes the bench toggles i_fire once per burst of first samples.
`timescale 1ns/100ps
`default_nettype none
module sfa_lvds_partner
  import sfa_pkg::*;
(
  input wire logic i_lvds_clk,
  input wire logic i_rstn,
  input wire sfa_lvds_state_s i_state,
  input wire logic i_fire,
  output sfa_lvds_state_s o_lvds_rx,
  output logic [2:0] o_first_sample
);
  logic [2:0] fire_sync;
  // Strobe already seen: receiver state settles on the link clock
  always_ff @(posedge i_lvds_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_lvds_rx <= '0;
      fire_sync <= 3'h0;
      o_first_sample <= 3'h0;
    end else begin
      o_lvds_rx <= i_state;
      fire_sync <= {fire_sync[1:0], i_fire};
      o_first_sample <= {3{fire_sync[2] ^ fire_sync[1]}};
    end
  end
endmodule : sfa_lvds_partner
`default_nettype wire

// >>> tb/sfa_sample_fifo_align_bench.sv
// Bench: SPI registers, strobe and SYSREF realignment, alarms, readbacks.
// Assumes the LVDS partner model; link clock runs free at 12 ns.
`timescale 1ns/100ps
`default_nettype none
module sfa_sample_fifo_align_bench
  import sfa_pkg::*;
  ;
  logic clk = 0, lclk = 0, rstn = 0, sclk = 0, csn = 1, sdi = 0;
  logic sysref = 0, datapath_enable = 0, aclr = 0, fire = 0, sdo, sdo_oe, realign, rstart;
  logic [1:0] mode = 2'h0;
  logic [4:0] dly = 5'h00;
  logic [2:0] off, fs, p0, p2, o;
  logic [7:0] rd_val, seen, c, v1, v2, v3, oe_v;
  logic ce = 1'b1;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h00006EBD;
  sfa_lvds_state_s st = '0, lvds_rx;
  sfa_alarm_s alm;
  int fail_count = 0, total_checks = 0, nn[2], nre = 0, nr;
  event seen_ev;
  initial forever #2 clk = ~clk;
  initial begin
    #1.3;
    forever #6 lclk = ~lclk;
  end
  sfa_sample_fifo_align dut (.i_core_clk(clk), .i_rstn(rstn), .i_core_ce(ce),
    .i_lvds_clk(lclk), .i_spi_sclk(sclk), .i_spi_csn(csn), .i_spi_sdi(sdi),
    .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe), .i_sysref(sysref), .i_datapath_enable(datapath_enable),
    .i_lvds_mode(mode), .i_fifo_delay_setting(dly), .i_lvds_rx(lvds_rx),
    .i_lvds_first_sample(fs), .i_alarm_clear(aclr), .o_alarm(alm),
    .o_fifo_read_offset(off), .o_fifo_realign(realign), .o_fifo_read_start(rstart));
  sfa_lvds_partner u_lvds (.i_lvds_clk(lclk), .i_rstn(rstn), .i_state(st), .i_fire(fire),
    .o_lvds_rx(lvds_rx), .o_first_sample(fs));
  always @(posedge clk) begin
    if (realign === 1'b1) nre <= nre + 1;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : check
  initial forever begin
    @(seen_ev);
    check(seen, exp_q.pop_front());
  end
  task automatic ex(input logic [7:0] got, input logic [7:0] exp);
    exp_q.push_back(exp);
    seen = got;
    ->seen_ev;
    cyc(1);
  endtask : ex
  task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] f;
    f = {r, a, d};
    csn <= 1'b0;
    cyc(4);
    for (int i = 23; i >= 0; i--) begin
      sdi <= f[i];
      sclk <= 1'b0;
      cyc(10);
      if (i < 8) begin
        rd_val[i] = sdo;
        oe_v[i] = sdo_oe;
      end
      sclk <= 1'b1;
      cyc(10);
    end
    sclk <= 1'b0;
    cyc(10);
    csn <= 1'b1;
    cyc(6);
  endtask : spi
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi(1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [14:0] a, output logic [7:0] v);
    spi(1'b1, a, 8'h00);
    v = rd_val;
  endtask : rd
  task automatic clr();
    aclr <= 1'b1;
    cyc(1);
    aclr <= 1'b0;
  endtask : clr
  task automatic sref(input int g);
    sysref <= 1'b1;
    cyc(1);
    sysref <= 1'b0;
    cyc(g - 1);
  endtask : sref
  task automatic strobe(input logic [7:0] base);
    wr(SFA_ADDR_ALIGN, base);
    wr(SFA_ADDR_ALIGN, base | 8'h02);
    cyc(40);
  endtask : strobe
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  initial begin
    cyc(12);
    rstn <= 1'b1;
    cyc(6);
    rd(SFA_ADDR_DLY_R1, v1);
    ex(v1, 8'h00);
    ex(oe_v, 8'hFF);
    rd(SFA_ADDR_DLY_R2, v1);
    ex(v1, 8'h00);
    rd(SFA_ADDR_DLY_R3, v1);
    ex(v1, 8'h00);
    rd(SFA_ADDR_ALIGN, v1);
    ex(v1, SFA_ALIGN_RESET);
    c = rnd() & 8'hFC;
    wr(SFA_ADDR_ALIGN, c);
    wr(15'h0300, 8'hFF);
    ex(oe_v, 8'h00);
    rd(SFA_ADDR_ALIGN, v1);
    ex(v1, c);
    rd(15'h0300, v1);
    ex(v1, 8'h00);
    $display("registers done");
    datapath_enable <= 1'b1;
    p0 = 3'(rnd()) | 3'h1;
    p2 = ~p0;
    st <= '{1'b1, p0, p2};
    strobe(c);
    ex({5'h00, off}, {5'h00, p0});
    ex({7'h00, alm.realigned}, 8'h01);
    st.bank0_phase <= p2;
    cyc(40);
    ex({5'h00, off}, {5'h00, p0});
    st <= '{1'b0, p0, p2};
    strobe(c);
    ex({5'h00, off}, {5'h00, p2});
    $display("strobe done");
    wr(SFA_ADDR_ALIGN, c | 8'h01);
    sref(8);
    clr();
    cyc(7);
    sref(20);
    ex({6'h00, alm}, 8'h00);
    nr = nre;
    sref(20);
    ex({6'h00, alm}, 8'h03);
    ex(8'(nre - nr), 8'h01);
    $display("sysref on done");
    o = off;
    nr = nre;
    st <= '{1'b1, o ^ 3'h1, p2};
    strobe(c);
    ex({5'h00, off}, {5'h00, o});
    ex(8'(nre - nr), 8'h00);
    datapath_enable <= 1'b0;
    cyc(2);
    datapath_enable <= 1'b1;
    strobe(c);
    ex({5'h00, off}, {5'h00, o ^ 3'h1});
    $display("lock done");
    wr(SFA_ADDR_ALIGN, c);
    clr();
    o = off;
    sref(19);
    sref(19);
    ex({6'h00, alm}, 8'h01);
    ex({5'h00, off}, {5'h00, o});
    ce <= 1'b0;
    clr();
    cyc(2);
    ce <= 1'b1;
    ex({6'h00, alm}, 8'h01);
    $display("sysref off done");
    for (int m = 0; m < 2; m++) begin
      mode <= 2'(m);
      dly <= (m == 1) ? 5'h0C : 5'h05;
      cyc(2);
      sysref <= 1'b1;
      nn[m] = 0;
      while (rstart !== 1'b1 && nn[m] < 100) begin
        cyc(1);
        nn[m]++;
      end
      sysref <= 1'b0;
      fire <= ~fire;
      cyc(30);
      rd(SFA_ADDR_DLY_R1, v1);
      rd(SFA_ADDR_DLY_R2, v2);
      rd(SFA_ADDR_DLY_R3, v3);
      ex(v1 - v2, (m == 1) ? 8'hFF : 8'h01);
      ex(v2 - v3, 8'h01);
    end
    ex(8'(nn[1] - nn[0]), 8'h07);
    $display("readback done");
    close_out();
  end
endmodule : sfa_sample_fifo_align_bench
`default_nettype wire
